// ===== spd_pkg.sv
// presence-detect store constants: content of the fixed bytes, map, link protocol
// assumes a two-wire serial link on its own clock and a 100 MHz system clock
package spd_pkg;
  localparam int          STORE_BYTES    = 256;
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  FIXED_TOP      = 8'h47;  // last constant location
  localparam logic [7:0]  MAKER_FIRST    = 8'h40;
  localparam logic [7:0]  MFG_FIRST      = 8'h48;
  localparam logic [7:0]  CUSTOMER_FIRST = 8'h80;
  localparam logic [7:0]  RESERVED_FIRST = 8'h24;
  localparam logic [7:0]  RESERVED_LAST  = 8'h3D;
  localparam logic [7:0]  UNDEFINED_BYTE = 8'h00;
  localparam logic [6:0]  DEV_ADDR_DEF   = 7'h50;
  localparam logic [63:0] MAKER_ID_DEF   = 64'h0123_4567_89AB_CDEF; // arbitrary value

  // register map offsets and values, grade independent
  localparam logic [7:0] BYTES_WRITTEN_COUNT_OFS = 8'h00;
  localparam logic [7:0] BYTES_WRITTEN_COUNT     = 8'h80;
  localparam logic [7:0] TOTAL_STORE_SIZE_OFS    = 8'h01;
  localparam logic [7:0] TOTAL_STORE_SIZE        = 8'h08;
  localparam logic [7:0] MEMORY_TYPE_OFS         = 8'h02;
  localparam logic [7:0] MEMORY_TYPE             = 8'h04;
  localparam logic [7:0] ROW_ADDRESS_BITS_OFS    = 8'h03;
  localparam logic [7:0] ROW_ADDRESS_BITS        = 8'h0B;
  localparam logic [7:0] COLUMN_ADDRESS_BITS_OFS = 8'h04;
  localparam logic [7:0] COLUMN_ADDRESS_BITS     = 8'h09;
  localparam logic [7:0] MODULE_ROW_COUNT_OFS    = 8'h05;
  localparam logic [7:0] MODULE_ROW_COUNT        = 8'h01;
  localparam logic [7:0] DATA_WIDTH_LOW_OFS      = 8'h06;
  localparam logic [7:0] DATA_WIDTH_LOW          = 8'h40;
  localparam logic [7:0] DATA_WIDTH_HIGH_OFS     = 8'h07;
  localparam logic [7:0] DATA_WIDTH_HIGH         = 8'h00;
  localparam logic [7:0] VOLTAGE_INTERFACE_OFS   = 8'h08;
  localparam logic [7:0] VOLTAGE_INTERFACE       = 8'h01;
  localparam logic [7:0] CYCLE_TIME_MAX_OFS      = 8'h09;
  localparam logic [7:0] CYCLE_TIME_MAX          = 8'hC0;
  localparam logic [7:0] ACCESS_TIME_MAX_OFS     = 8'h0A;
  localparam logic [7:0] ACCESS_TIME_MAX         = 8'h90;
  localparam logic [7:0] CONFIG_TYPE_OFS         = 8'h0B;
  localparam logic [7:0] CONFIG_TYPE             = 8'h00;
  localparam logic [7:0] REFRESH_RATE_TYPE_OFS   = 8'h0C;
  localparam logic [7:0] REFRESH_RATE_TYPE       = 8'h80;
  localparam logic [7:0] PRIMARY_DRAM_WIDTH_OFS  = 8'h0D;
  localparam logic [7:0] PRIMARY_DRAM_WIDTH      = 8'h08;
  localparam logic [7:0] ERROR_CHECK_WIDTH_OFS   = 8'h0E;
  localparam logic [7:0] ERROR_CHECK_WIDTH       = 8'h00;
  localparam logic [7:0] COL_TO_COL_DELAY_OFS    = 8'h0F;
  localparam logic [7:0] COL_TO_COL_DELAY        = 8'h01;
  localparam logic [7:0] BURST_LENGTHS_MASK_OFS  = 8'h10;
  localparam logic [7:0] BURST_LENGTHS_MASK      = 8'h0F;
  localparam logic [7:0] INTERNAL_BANK_COUNT_OFS = 8'h11;
  localparam logic [7:0] INTERNAL_BANK_COUNT     = 8'h02;
  localparam logic [7:0] CAS_LATENCY_MASK_OFS    = 8'h12;
  localparam logic [7:0] CAS_LATENCY_MASK        = 8'h06;
  localparam logic [7:0] CHIP_SELECT_LAT_OFS     = 8'h13;
  localparam logic [7:0] CHIP_SELECT_LAT         = 8'h01;
  localparam logic [7:0] WRITE_LATENCY_OFS       = 8'h14;
  localparam logic [7:0] WRITE_LATENCY           = 8'h01;
  localparam logic [7:0] MODULE_ATTRIBUTES_OFS   = 8'h15;
  localparam logic [7:0] MODULE_ATTRIBUTES       = 8'h00;
  localparam logic [7:0] DEVICE_ATTRIBUTES_OFS   = 8'h16;
  localparam logic [7:0] CYCLE_TIME_M1_OFS       = 8'h17;
  localparam logic [7:0] ACCESS_TIME_M1_OFS      = 8'h18;
  localparam logic [7:0] CYCLE_TIME_M2_OFS       = 8'h19;
  localparam logic [7:0] CYCLE_TIME_M2           = 8'h00;
  localparam logic [7:0] ACCESS_TIME_M2_OFS      = 8'h1A;
  localparam logic [7:0] ACCESS_TIME_M2          = 8'h00;
  localparam logic [7:0] ROW_PRECHARGE_MIN_OFS   = 8'h1B;
  localparam logic [7:0] ACT_TO_ACT_MIN_OFS      = 8'h1C;
  localparam logic [7:0] ACT_TO_ACT_MIN          = 8'h18;
  localparam logic [7:0] ROW_TO_COLUMN_MIN_OFS   = 8'h1D;
  localparam logic [7:0] ROW_TO_COLUMN_MIN       = 8'h1E;
  localparam logic [7:0] ROW_ACTIVE_MIN_OFS      = 8'h1E;
  localparam logic [7:0] BANK_DENSITY_OFS        = 8'h1F;
  localparam logic [7:0] BANK_DENSITY            = 8'h04;
  localparam logic [7:0] CMD_ADDR_SETUP_OFS      = 8'h20;
  localparam logic [7:0] CMD_ADDR_SETUP          = 8'h30;
  localparam logic [7:0] CMD_ADDR_HOLD_OFS       = 8'h21;
  localparam logic [7:0] DATA_INPUT_SETUP_OFS    = 8'h22;
  localparam logic [7:0] DATA_INPUT_SETUP        = 8'h30;
  localparam logic [7:0] DATA_INPUT_HOLD_OFS     = 8'h23;
  localparam logic [7:0] SPD_REVISION_OFS        = 8'h3E;
  localparam logic [7:0] SPD_REVISION            = 8'h02;
  localparam logic [7:0] HEADER_CHECKSUM_OFS     = 8'h3F;

  // grade dependent values: index 1 faster grade, index 0 slower grade
  localparam logic [7:0] DEVICE_ATTRIBUTES_FAST  = 8'h1E;
  localparam logic [7:0] DEVICE_ATTRIBUTES_SLOW  = 8'h0E;
  localparam logic [7:0] CYCLE_TIME_M1_FAST      = 8'hF0;
  localparam logic [7:0] CYCLE_TIME_M1_SLOW      = 8'h30;
  localparam logic [7:0] ACCESS_TIME_M1_FAST     = 8'h90;
  localparam logic [7:0] ACCESS_TIME_M1_SLOW     = 8'hA0;
  localparam logic [7:0] ROW_PRECHARGE_MIN_FAST  = 8'h1E;
  localparam logic [7:0] ROW_PRECHARGE_MIN_SLOW  = 8'h24;
  localparam logic [7:0] ROW_ACTIVE_MIN_FAST     = 8'h3C;
  localparam logic [7:0] ROW_ACTIVE_MIN_SLOW     = 8'h48;
  localparam logic [7:0] INPUT_HOLD_FAST         = 8'h10;
  localparam logic [7:0] INPUT_HOLD_SLOW         = 8'h15;
  localparam logic [7:0] HEADER_CHECKSUM_FAST    = 8'h88;
  localparam logic [7:0] HEADER_CHECKSUM_SLOW    = 8'hE4;

  // link protocol
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic       DIR_READ   = 1'b1;
  localparam logic       ACK_LEVEL  = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_DEV_ADDR  = 4'b0001,
    ST_ACK_DEV   = 4'b0010,
    ST_WORD_ADDR = 4'b0011,
    ST_ACK_WORD  = 4'b0100,
    ST_WR_DATA   = 4'b0101,
    ST_ACK_WR    = 4'b0110,
    ST_RD_DATA   = 4'b0111,
    ST_RD_ACK    = 4'b1000
  } link_state_e;
endpackage

// ===== spd_config_rom.sv
// presence-detect store: 256-byte two-wire slave with fixed maker header
// assumes scl is the link clock from the master; sda is open drain, rstn syncs to scl for the link
`timescale 1ns/100ps
module spd_config_rom #(
  parameter bit          FAST_GRADE = 1'b1,
  parameter logic [6:0]  DEV_ADDR   = spd_pkg::DEV_ADDR_DEF,
  parameter logic [63:0] MAKER_ID   = spd_pkg::MAKER_ID_DEF
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic mfg_unlock,
  output logic      customer_write
);

  typedef struct packed {
    spd_pkg::link_state_e state;
    logic [7:0]           shift;
    logic [2:0]           bit_cnt;
    logic [7:0]           ptr;
    logic                 dir_read;
    logic                 start_seen;
    logic                 wr_tog;
  } link_s;

  typedef struct packed {
    logic [2:0] wr_sync;
    logic       pulse;
  } sys_s;

  link_s      link;
  link_s      next_link;
  sys_s       sys;
  sys_s       next_sys;
  logic [1:0] rst_sync;
  logic [1:0] unlock_sync;
  logic       link_rst;
  logic       start_tog;
  logic       drive_low;
  logic       wr_go;
  logic [7:0] rx_byte;
  logic [7:0] mem [spd_pkg::STORE_BYTES];

  initial begin
    if (spd_pkg::STORE_BYTES != (1 << spd_pkg::ADDR_W))
      $error("store size must match the pointer width");
  end

  // fixed content, grade selected at build time
  function automatic logic [7:0] fixed_byte(input logic [7:0] a);
    logic [7:0] v;
    v = spd_pkg::UNDEFINED_BYTE;
    case (a)
      spd_pkg::BYTES_WRITTEN_COUNT_OFS: v = spd_pkg::BYTES_WRITTEN_COUNT;
      spd_pkg::TOTAL_STORE_SIZE_OFS:    v = spd_pkg::TOTAL_STORE_SIZE;
      spd_pkg::MEMORY_TYPE_OFS:         v = spd_pkg::MEMORY_TYPE;
      spd_pkg::ROW_ADDRESS_BITS_OFS:    v = spd_pkg::ROW_ADDRESS_BITS;
      spd_pkg::COLUMN_ADDRESS_BITS_OFS: v = spd_pkg::COLUMN_ADDRESS_BITS;
      spd_pkg::MODULE_ROW_COUNT_OFS:    v = spd_pkg::MODULE_ROW_COUNT;
      spd_pkg::DATA_WIDTH_LOW_OFS:      v = spd_pkg::DATA_WIDTH_LOW;
      spd_pkg::DATA_WIDTH_HIGH_OFS:     v = spd_pkg::DATA_WIDTH_HIGH;
      spd_pkg::VOLTAGE_INTERFACE_OFS:   v = spd_pkg::VOLTAGE_INTERFACE;
      spd_pkg::CYCLE_TIME_MAX_OFS:      v = spd_pkg::CYCLE_TIME_MAX;
      spd_pkg::ACCESS_TIME_MAX_OFS:     v = spd_pkg::ACCESS_TIME_MAX;
      spd_pkg::CONFIG_TYPE_OFS:         v = spd_pkg::CONFIG_TYPE;
      spd_pkg::REFRESH_RATE_TYPE_OFS:   v = spd_pkg::REFRESH_RATE_TYPE;
      spd_pkg::PRIMARY_DRAM_WIDTH_OFS:  v = spd_pkg::PRIMARY_DRAM_WIDTH;
      spd_pkg::ERROR_CHECK_WIDTH_OFS:   v = spd_pkg::ERROR_CHECK_WIDTH;
      spd_pkg::COL_TO_COL_DELAY_OFS:    v = spd_pkg::COL_TO_COL_DELAY;
      spd_pkg::BURST_LENGTHS_MASK_OFS:  v = spd_pkg::BURST_LENGTHS_MASK;
      spd_pkg::INTERNAL_BANK_COUNT_OFS: v = spd_pkg::INTERNAL_BANK_COUNT;
      spd_pkg::CAS_LATENCY_MASK_OFS:    v = spd_pkg::CAS_LATENCY_MASK;
      spd_pkg::CHIP_SELECT_LAT_OFS:     v = spd_pkg::CHIP_SELECT_LAT;
      spd_pkg::WRITE_LATENCY_OFS:       v = spd_pkg::WRITE_LATENCY;
      spd_pkg::MODULE_ATTRIBUTES_OFS:   v = spd_pkg::MODULE_ATTRIBUTES;
      spd_pkg::DEVICE_ATTRIBUTES_OFS:
        v = FAST_GRADE ? spd_pkg::DEVICE_ATTRIBUTES_FAST : spd_pkg::DEVICE_ATTRIBUTES_SLOW;
      spd_pkg::CYCLE_TIME_M1_OFS:
        v = FAST_GRADE ? spd_pkg::CYCLE_TIME_M1_FAST : spd_pkg::CYCLE_TIME_M1_SLOW;
      spd_pkg::ACCESS_TIME_M1_OFS:
        v = FAST_GRADE ? spd_pkg::ACCESS_TIME_M1_FAST : spd_pkg::ACCESS_TIME_M1_SLOW;
      spd_pkg::CYCLE_TIME_M2_OFS:       v = spd_pkg::CYCLE_TIME_M2;
      spd_pkg::ACCESS_TIME_M2_OFS:      v = spd_pkg::ACCESS_TIME_M2;
      spd_pkg::ROW_PRECHARGE_MIN_OFS:
        v = FAST_GRADE ? spd_pkg::ROW_PRECHARGE_MIN_FAST : spd_pkg::ROW_PRECHARGE_MIN_SLOW;
      spd_pkg::ACT_TO_ACT_MIN_OFS:      v = spd_pkg::ACT_TO_ACT_MIN;
      spd_pkg::ROW_TO_COLUMN_MIN_OFS:   v = spd_pkg::ROW_TO_COLUMN_MIN;
      spd_pkg::ROW_ACTIVE_MIN_OFS:
        v = FAST_GRADE ? spd_pkg::ROW_ACTIVE_MIN_FAST : spd_pkg::ROW_ACTIVE_MIN_SLOW;
      spd_pkg::BANK_DENSITY_OFS:        v = spd_pkg::BANK_DENSITY;
      spd_pkg::CMD_ADDR_SETUP_OFS:      v = spd_pkg::CMD_ADDR_SETUP;
      spd_pkg::DATA_INPUT_SETUP_OFS:    v = spd_pkg::DATA_INPUT_SETUP;
      spd_pkg::CMD_ADDR_HOLD_OFS,
      spd_pkg::DATA_INPUT_HOLD_OFS:
        v = FAST_GRADE ? spd_pkg::INPUT_HOLD_FAST : spd_pkg::INPUT_HOLD_SLOW;
      spd_pkg::SPD_REVISION_OFS:        v = spd_pkg::SPD_REVISION;
      spd_pkg::HEADER_CHECKSUM_OFS:
        v = FAST_GRADE ? spd_pkg::HEADER_CHECKSUM_FAST : spd_pkg::HEADER_CHECKSUM_SLOW;
      default: begin
        // maker code, first byte at the lowest location
        if (a >= spd_pkg::MAKER_FIRST && a <= spd_pkg::FIXED_TOP)
          v = MAKER_ID[8'd63 - ((a - spd_pkg::MAKER_FIRST) << 3) -: 8];
        else
          v = spd_pkg::UNDEFINED_BYTE;
      end
    endcase
    return v;
  endfunction

  // header below 72 is constant, the rest lives in the array
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] v;
    v = (a <= spd_pkg::FIXED_TOP) ? fixed_byte(a) : mem[a];
    return v;
  endfunction

  // reset and strap levels into the link domain
  always_ff @(posedge scl) begin
    rst_sync    <= {rst_sync[0], rstn};
    unlock_sync <= {unlock_sync[0], mfg_unlock};
  end
  assign link_rst = ~rst_sync[1];

  // start: data falls while the clock is high; cleared so the toggle is never unknown
  always_ff @(negedge sda_in or posedge link_rst) begin
    if (link_rst)
      start_tog <= 1'b0;
    else if (scl)
      start_tog <= ~start_tog;
  end

  assign rx_byte = {link.shift[6:0], sda_in};

  always_comb begin
    next_link            = link;
    wr_go                = 1'b0;
    next_link.start_seen = start_tog;
    if (link.start_seen != start_tog) begin
      next_link.state   = spd_pkg::ST_DEV_ADDR;
      next_link.shift   = {7'h00, sda_in};
      next_link.bit_cnt = 3'h1;
    end else begin
      case (link.state)
        spd_pkg::ST_DEV_ADDR, spd_pkg::ST_WORD_ADDR, spd_pkg::ST_WR_DATA: begin
          next_link.shift   = rx_byte;
          next_link.bit_cnt = link.bit_cnt + 3'h1;
          if (link.bit_cnt == spd_pkg::BIT_LAST) begin
            case (link.state)
              spd_pkg::ST_DEV_ADDR: begin
                next_link.dir_read = rx_byte[0];
                next_link.state    = (rx_byte[7:1] == DEV_ADDR) ? spd_pkg::ST_ACK_DEV : spd_pkg::ST_IDLE;
              end
              spd_pkg::ST_WORD_ADDR: begin
                next_link.ptr   = rx_byte;
                next_link.state = spd_pkg::ST_ACK_WORD;
              end
              default: begin
                // customer half always, manufacture half only when unlocked
                wr_go = link.ptr >= spd_pkg::CUSTOMER_FIRST ||
                        (link.ptr >= spd_pkg::MFG_FIRST && unlock_sync[1]);
                next_link.wr_tog = link.wr_tog ^ wr_go;
                next_link.ptr    = link.ptr + 8'h01;
                next_link.state  = spd_pkg::ST_ACK_WR;
              end
            endcase
          end
        end
        spd_pkg::ST_ACK_DEV: begin
          next_link.bit_cnt = 3'h0;
          if (link.dir_read == spd_pkg::DIR_READ) begin
            next_link.shift = read_byte(link.ptr);
            next_link.ptr   = link.ptr + 8'h01;
            next_link.state = spd_pkg::ST_RD_DATA;
          end else begin
            next_link.state = spd_pkg::ST_WORD_ADDR;
          end
        end
        spd_pkg::ST_ACK_WORD, spd_pkg::ST_ACK_WR: begin
          next_link.bit_cnt = 3'h0;
          next_link.state   = spd_pkg::ST_WR_DATA;
        end
        spd_pkg::ST_RD_DATA: begin
          next_link.shift   = {link.shift[6:0], 1'b0};
          next_link.bit_cnt = link.bit_cnt + 3'h1;
          if (link.bit_cnt == spd_pkg::BIT_LAST)
            next_link.state = spd_pkg::ST_RD_ACK;
        end
        spd_pkg::ST_RD_ACK: begin
          next_link.bit_cnt = 3'h0;
          if (sda_in == spd_pkg::ACK_LEVEL) begin
            next_link.shift = read_byte(link.ptr);
            next_link.ptr   = link.ptr + 8'h01;
            next_link.state = spd_pkg::ST_RD_DATA;
          end else begin
            next_link.state = spd_pkg::ST_IDLE;
          end
        end
        spd_pkg::ST_IDLE: next_link.state = spd_pkg::ST_IDLE;
        default:          next_link.state = spd_pkg::ST_IDLE;
      endcase
    end
    if (link_rst) begin
      next_link            = '0;
      next_link.state      = spd_pkg::ST_IDLE;
      next_link.start_seen = start_tog;
      wr_go                = 1'b0;
    end
  end

  always_ff @(posedge scl) begin
    link <= next_link;
  end

  // nonvolatile array, no reset
  always_ff @(posedge scl) begin
    if (wr_go)
      mem[link.ptr] <= rx_byte;
  end

  // output data changes only while the clock is low
  always_comb begin
    case (link.state)
      spd_pkg::ST_ACK_DEV, spd_pkg::ST_ACK_WORD, spd_pkg::ST_ACK_WR: drive_low = 1'b1;
      spd_pkg::ST_RD_DATA: drive_low = ~link.shift[7];
      default:             drive_low = 1'b0;
    endcase
  end

  always_ff @(negedge scl) begin
    sda_out <= 1'b0;
    sda_oe  <= link_rst ? 1'b0 : drive_low;
  end

  // write event crossing by toggle into the system clock
  always_comb begin
    next_sys       = sys;
    next_sys.wr_sync = {sys.wr_sync[1:0], link.wr_tog};
    next_sys.pulse = sys.wr_sync[2] ^ sys.wr_sync[1];
    if (!rstn)
      next_sys = '0;
  end

  always_ff @(posedge ref_clk) begin
    sys <= next_sys;
  end

  always_ff @(posedge ref_clk) begin
    customer_write <= rstn ? next_sys.pulse : 1'b0;
  end

endmodule

// ===== spd_config_rom_properties.sv
// checker for the presence-detect store: link framing and write strobe
// assumes sda_in is the resolved wire and the master changes sda only while scl is low, except to signal a start
`timescale 1ns/100ps
module spd_config_rom_properties #(
  parameter logic [6:0] DEV_ADDR = spd_pkg::DEV_ADDR_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic mfg_unlock,
  input wire logic customer_write
);
  logic       sda_rise;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       is_addr;
  logic       sel;
  logic       rd;

  // level seen at the rise; a fall at the next scl fall marks a start
  always_ff @(posedge scl) sda_rise <= sda_in;

  always_ff @(negedge scl) begin
    if (sda_rise && !sda_in) begin
      cnt     <= 4'h0;
      is_addr <= 1'b1;
      sel     <= 1'b0;
    end else begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      sh  <= {sh[6:0], sda_rise};
      if (cnt == 4'h8 && is_addr) begin
        is_addr <= 1'b0;
        sel     <= (sh[7:1] == DEV_ADDR);
        rd      <= sh[0];
      end
    end
  end

  a_sda_never_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    sda_out == 1'b0) else $error("sda output not low");
  a_oe_scl_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    !$stable(sda_oe) |-> !scl) else $error("sda changed while scl high");
  a_reset_quiet: assert property (@(posedge ref_clk)
    !rstn |=> !customer_write) else $error("write strobe during reset");
  a_pulse_spaced: assert property (@(posedge ref_clk) disable iff (!rstn)
    customer_write |=> !customer_write [*8]) else $error("write strobe too long or too close");
  a_addr_ack: assert property (@(posedge scl) disable iff (!rstn)
    cnt == 4'h8 && is_addr && sh[7:1] == DEV_ADDR |-> sda_oe) else $error("own address not acked");
  a_addr_ignore: assert property (@(posedge scl) disable iff (!rstn)
    cnt == 4'h8 && is_addr && sh[7:1] != DEV_ADDR |-> !sda_oe) else $error("foreign address acked");
  a_byte_ack: assert property (@(posedge scl) disable iff (!rstn)
    cnt == 4'h8 && !is_addr && sel && !rd |-> sda_oe) else $error("written byte not acked");
  a_read_turn: assert property (@(posedge scl) disable iff (!rstn)
    cnt == 4'h8 && !is_addr && sel && rd |-> !sda_oe) else $error("driving in master ack slot");
  a_idle_silent: assert property (@(posedge scl) disable iff (!rstn)
    !is_addr && !sel |-> !sda_oe) else $error("driving while not addressed");

  c_addr_ack: cover property (@(posedge scl) cnt == 4'h8 && is_addr && sda_oe);
  c_write_pulse: cover property (@(posedge ref_clk) customer_write);
  c_read_turn: cover property (@(posedge scl) cnt == 4'h8 && !is_addr && sel && rd);
endmodule

bind spd_config_rom spd_config_rom_properties #(.DEV_ADDR(DEV_ADDR)) i_spd_config_rom_properties (
  .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .mfg_unlock(mfg_unlock), .customer_write(customer_write));

// ===== spd_host_model.sv
// host side of the two-wire link: clock, start and byte transfers
// assumes sda is pulled up and scl stands still between frames
`timescale 1ns/100ps
module spd_host_model (
  output logic      scl,
  output logic      sda_drive,
  input  wire logic sda
);
  localparam realtime Q = 31.25;

  initial begin
    scl = 1'b0;
    sda_drive = 1'b0;
  end

  // data set while scl low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    #Q sda_drive = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask

  // sda falls while scl high
  task automatic start();
    #Q sda_drive = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drive = 1'b1;
    #Q scl = 1'b0;
  endtask

  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ninth);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, ninth);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      #(2*Q) scl = 1'b1;
      #(2*Q) scl = 1'b0;
    end
  endtask
endmodule

// ===== spd_config_rom_test.sv
// testbench: both speed grades share one link, host model drives it
// assumes a 100 MHz ref_clk and a 125 ns link clock from the host model
`timescale 1ns/100ps
module spd_config_rom_test;
  localparam logic [63:0] MAKER = 64'hA5C3_1E78_0F96_4B2D; // arbitrary value
  localparam logic [6:0]  DEV_F = 7'h50;
  localparam logic [6:0]  DEV_S = 7'h51;
  logic        ref_clk    = 1'b0;
  logic        rstn       = 1'b0;
  logic        mfg_unlock = 1'b0;
  logic        scl;
  logic        drv;
  logic        oe_f;
  logic        oe_s;
  logic        cw_f;
  logic        cw_s;
  wire         sda = (drv | oe_f | oe_s) ? 1'b0 : 1'b1;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          wr_pulses   = 0;
  logic [31:0] seed = 32'h5C26D2C8;
  logic [7:0]  rx_buf [72];

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (cw_f === 1'b1) wr_pulses++;
    if (cw_s === 1'b1) wr_pulses++;
  end

  spd_config_rom #(.FAST_GRADE(1'b1), .DEV_ADDR(DEV_F), .MAKER_ID(MAKER)) i_spd_config_rom (
    .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(oe_f),
    .mfg_unlock(mfg_unlock), .customer_write(cw_f));
  spd_config_rom #(.FAST_GRADE(1'b0), .DEV_ADDR(DEV_S), .MAKER_ID(MAKER)) i_spd_config_rom_slow (
    .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(oe_s),
    .mfg_unlock(mfg_unlock), .customer_write(cw_s));
  spd_host_model i_spd_host_model (.scl(scl), .sda_drive(drv), .sda(sda));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_byte(input logic fast, input logic [7:0] a);
    logic [287:0] t;
    t = fast ? 288'h8008040B_09014000_01C09000_80080001_0F020601_01001EF0_9000001E_181E3C04_30103010
             : 288'h8008040B_09014000_01C09000_80080001_0F020601_01000E30_A0000024_181E4804_30153015;
    if (a < 8'd36) return t[287 - 8*int'(a) -: 8];
    if (a == 8'd62) return 8'h02;
    if (a == 8'd63) return fast ? 8'h88 : 8'hE4;
    if (a >= 8'd64 && a < 8'd72) return MAKER[63 - 8*(int'(a) - 64) -: 8];
    return 8'h00;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input int lo, input int hi, input logic fast);
    for (int i = lo; i <= hi; i++) chk(rx_buf[i], exp_byte(fast, 8'(i)));
  endtask

  // absent devices leave every ack slot high
  task automatic point(input logic [6:0] dev, input logic [7:0] a);
    logic [7:0] rx;
    logic       k;
    i_spd_host_model.start();
    i_spd_host_model.xfer({dev, 1'b0}, 1'b1, rx, k);
    chk({7'h00, k}, {7'h00, dev != DEV_F && dev != DEV_S});
    i_spd_host_model.xfer(a, 1'b1, rx, k);
    chk({7'h00, k}, {7'h00, dev != DEV_F && dev != DEV_S});
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input int n, input logic [31:0] w);
    logic [7:0] rx;
    logic       k;
    point(dev, a);
    for (int i = 0; i < n; i++) begin
      i_spd_host_model.xfer(w[31 - 8*i -: 8], 1'b1, rx, k);
      chk({7'h00, k}, {7'h00, dev != DEV_F && dev != DEV_S});
    end
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] a, input int n);
    logic [7:0] rx;
    logic       k;
    point(dev, a);
    i_spd_host_model.start();
    i_spd_host_model.xfer({dev, 1'b1}, 1'b1, rx, k);
    for (int i = 0; i < n; i++) begin
      i_spd_host_model.xfer(8'hFF, i == n - 1, rx, k);
      rx_buf[i] = rx;
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #900_000;
    fail_count++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  sum;
    int          p0;
    int          n;
    i_spd_host_model.pulses(5);
    @(negedge ref_clk) rstn <= 1'b1;
    i_spd_host_model.pulses(3);
    for (int g = 0; g < 2; g++) begin
      rd(g ? DEV_S : DEV_F, 8'h00, 72);
      chk_range(0, 12, g == 0);
      chk_range(13, 21, g == 0);
      chk_range(22, 35, g == 0);
      chk_range(36, 71, g == 0);
      sum = 8'h00;
      for (int i = 0; i < 63; i++) sum += rx_buf[i];
      chk(sum, rx_buf[63]);
    end
    repeat (16) begin
      r = rnd();
      a = 8'(r[15:0] % 72);
      rd(r[16] ? DEV_S : DEV_F, a, 1);
      chk(rx_buf[0], exp_byte(!r[16], a));
    end
    r = rnd();
    a = 8'(r[15:0] % 72);
    p0 = wr_pulses;
    wr(DEV_F, a, 1, r);
    rd(DEV_F, a, 1);
    chk(rx_buf[0], exp_byte(1'b1, a));
    chk(8'(wr_pulses - p0), 8'h00);
    rd(7'h52, 8'h00, 1);
    chk(rx_buf[0], 8'hFF);
    for (int c = 0; c < 2; c++) begin
      r = rnd();
      a = c ? 8'hFD : 8'h80 + 8'(r[15:0] % 39);
      p0 = wr_pulses;
      n = 0;
      wr(DEV_S, a, 4, r);
      repeat (20) @(negedge ref_clk);
      rd(DEV_S, a, 4);
      for (int i = 0; i < 4; i++) begin
        b = a + 8'(i);
        chk(rx_buf[i], b[7] ? r[31 - 8*i -: 8] : exp_byte(1'b0, b));
        n += int'(b[7]);
      end
      chk(8'(wr_pulses - p0), 8'(n));
    end
    @(negedge ref_clk) mfg_unlock <= 1'b1;
    r = rnd();
    a = 8'h48 + 8'(r[15:0] % 56);
    p0 = wr_pulses;
    wr(DEV_F, a, 1, r);
    @(negedge ref_clk) mfg_unlock <= 1'b0;
    wr(DEV_F, a, 1, ~r);
    rd(DEV_F, a, 1);
    chk(rx_buf[0], r[31:24]);
    chk(8'(wr_pulses - p0), 8'h01);
    close_out();
  end
endmodule
